//--- inc/ita_pkg.sv
/*
 Shared constants and types of the indirect table access block.
 Assumes a 32-bit APB master and the single switch clock.
*/
`default_nettype none
package ita_pkg;
   // Printed offsets are register indices; byte address is four times the index
   localparam logic [9:0] IDX_DATA_TOP = 10'h027;
   localparam logic [9:0] IDX_DATA_W2 = 10'h028;
   localparam logic [9:0] IDX_DATA_W3 = 10'h02a;
   localparam logic [9:0] IDX_DATA_W0 = 10'h02c;
   localparam logic [9:0] IDX_DATA_W1 = 10'h02e;
   localparam logic [9:0] IDX_CTRL = 10'h030;
   localparam int TOP_BUSY_BIT = 7;
   localparam int TOP_NOT_READY_BIT = 6;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [15:0] CTRL_RESET = 16'h0000;

   localparam int STATIC_DEPTH = 8;
   localparam int VLAN_DEPTH = 16;
   localparam int LEARN_DEPTH = 1024;
   localparam int MIB_DEPTH = 96;
   localparam int DROP_COUNT = 6;
   localparam logic [9:0] STATS_PORT1_BASE = 10'h000;
   localparam logic [9:0] STATS_PORT2_BASE = 10'h020;
   localparam logic [9:0] STATS_PORT3_BASE = 10'h040;
   localparam logic [9:0] STATS_DROP_BASE = 10'h100;
   localparam logic [10:0] LEARN_MAX = 11'h400;
   localparam logic [29:0] MIB_COUNT_MAX = 30'h3fffffff;
   localparam int COMMIT_CYCLES = 2;

   typedef enum logic [1:0] {
      TSEL_STATIC = 2'h0,
      TSEL_VLAN = 2'h1,
      TSEL_LEARN = 2'h2,
      TSEL_STATS = 2'h3
   } ita_tsel_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_WRITE = 2'b10
   } ita_state_t;

   typedef struct packed {
      logic [2:0] rsvd;
      logic readSel;
      ita_tsel_t tsel;
      logic [9:0] index;
   } ita_ctrl_t;

   typedef struct packed {
      logic [3:0] fid;
      logic useFid;
      logic override;
      logic valid;
      logic [2:0] ports;
      logic [47:0] mac;
   } ita_static_t;

   typedef struct packed {
      logic valid;
      logic [2:0] member;
      logic [3:0] fid;
      logic [11:0] vid;
   } ita_vlan_t;

   typedef struct packed {
      logic [1:0] stamp;
      logic [1:0] srcPort;
      logic [3:0] fid;
      logic [47:0] mac;
   } ita_learn_t;

   typedef struct packed {
      logic overflow;
      logic valid;
      logic [29:0] count;
   } ita_mib_t;

   localparam ita_vlan_t VLAN_RESET = '{valid: 1'b1, member: 3'h7, fid: 4'h0, vid: 12'h001};
   localparam ita_static_t STATIC_RESET = '0;
   localparam ita_mib_t MIB_RESET = '0;
endpackage
`default_nettype wire

//--- core/ita_top.sv
/*
 Indirect table access: APB register bank, static MAC, VLAN, learned MAC
 and statistics tables, static MAC lookup.
 Assumes a zero-wait APB master, the single switch clock and learning and
 counting events from the switch datapath synchronous to that clock.
*/
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - A read trigger loads the selected entry into the data registers.
// - Table select 0 static, 1 VLAN, 2 learned, 3 statistics.
// - Ten-bit index selects the entry in the chosen table.
// - Read-select set means read, clear means write.
// - Counter word: overflow bit 31, valid bit 30, count 29..0; count and overflow cleared on read.
// - Per-port counters at 0x00, 0x20, 0x40, 32 each.
// - Six drop counters at 0x100..0x105, 16 bits, read without clearing.
// - Static table: eight entries, address 47..0, port mask 50..48.
// - Matching static entry forwards to mask ports; zero none, seven all.
// - Static valid bit 51; invalid entries never match.
// - Override bit 52 ignores port transmit and receive disables.
// - Use-filter bit 53 matches filter id 57..54 plus address.
// - Learned table indexed 0..0x3FF, read-only to software.
// - Bit 71 flags learned data not ready; software retries. Here the flag reads at top register bit 6 (entry bit 70); top bit 7 is busy.
// - Bit 66 flags empty; else count equals field 65..56 plus one.
// - Learned entry reports stamp, filter id and learned address.
// - Source port field: 0 port 1, 1 port 2, 2 port 3.
// - VLAN table: 16 entries, id 11..0, filter 15..12, valid 19.
// - VLAN membership 18..16 resets to all ports, id 1, valid set.
module ita_top
   import ita_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic learnWr,
   input wire logic learnNew,
   input wire logic learnFlush,
   input wire logic [9:0] learnIdx,
   input wire ita_learn_t learnEntry,
   input wire logic mibInc,
   input wire logic [6:0] mibIdx,
   input wire logic [DROP_COUNT-1:0] dropInc,
   input wire logic lkpReq,
   input wire logic [47:0] lkpMac,
   input wire logic [3:0] lkpFid,
   input wire logic [1:0] lkpSrcPort,
   input wire logic [2:0] txDisable,
   input wire logic [2:0] rxDisable,
   output logic lkpHit,
   output logic [2:0] lkpPorts
);
   function automatic logic isReg(input logic [11:0] addr, input logic [9:0] idx);
      isReg = (addr == {idx, 2'b00});
   endfunction

   function automatic logic [2:0] portBit(input logic [1:0] p);
      portBit = (p == 2'd3) ? 3'h0 : 3'((3'h1) << p);
   endfunction

   ita_static_t staticTab [STATIC_DEPTH];
   ita_vlan_t vlanTab [VLAN_DEPTH];
   ita_learn_t learnTab [LEARN_DEPTH];
   ita_mib_t mibTab [MIB_DEPTH];
   logic [15:0] dropTab [DROP_COUNT];
   logic [10:0] learnCount;
   ita_ctrl_t ctrl;
   ita_state_t state;
   logic [15:0] word0, word1, word2, word3;
   logic [2:0] topBits;
   logic notReady;
   logic [71:0] rdEntry;
   logic [63:0] wrEntry;
   logic apbAccess, apbWr, mapped;
   logic ctrlWr, loadNow, commitNow;
   logic [6:0] statIdx;
   logic [2:0] dropIdx;
   logic isMib, isDrop;
   logic next_hit, next_ovr;
   logic [2:0] next_ports;

   assign apbAccess = psel & penable;
   assign apbWr = apbAccess & pwrite;
   assign pready = 1'b1;
   assign mapped = isReg(paddr, IDX_DATA_TOP) | isReg(paddr, IDX_DATA_W2) |
      isReg(paddr, IDX_DATA_W3) | isReg(paddr, IDX_DATA_W0) |
      isReg(paddr, IDX_DATA_W1) | isReg(paddr, IDX_CTRL);
   assign pslverr = apbAccess & ~mapped;
   assign ctrlWr = apbWr & isReg(paddr, IDX_CTRL) & (state == ST_IDLE);
   assign loadNow = (state == ST_READ);
   assign commitNow = (state == ST_WRITE);
   assign statIdx = ctrl.index[6:0];
   assign dropIdx = ctrl.index[2:0];
   assign isMib = (ctrl.index < 10'(MIB_DEPTH));
   assign isDrop = (ctrl.index >= STATS_DROP_BASE) &&
      (ctrl.index < STATS_DROP_BASE + 10'(DROP_COUNT));
   assign wrEntry = {word3, word2, word1, word0};

   always_comb
   begin
      prdata = 32'h0000_0000;
      if (isReg(paddr, IDX_DATA_TOP))
      begin
         prdata[TOP_BUSY_BIT] = loadNow;
         prdata[TOP_NOT_READY_BIT] = notReady;
         prdata[2:0] = topBits;
      end
      else if (isReg(paddr, IDX_DATA_W2))
         prdata[15:0] = word2;
      else if (isReg(paddr, IDX_DATA_W3))
         prdata[15:0] = word3;
      else if (isReg(paddr, IDX_DATA_W0))
         prdata[15:0] = word0;
      else if (isReg(paddr, IDX_DATA_W1))
         prdata[15:0] = word1;
      else if (isReg(paddr, IDX_CTRL))
         prdata[15:0] = ctrl;
   end

   // Control register and sequencer
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         ctrl <= CTRL_RESET;
         state <= ST_IDLE;
      end
      else
      begin
         unique case (state)
            ST_IDLE:
            begin
               if (ctrlWr)
               begin
                  ctrl <= pwdata[15:0];
                  state <= pwdata[12] ? ST_READ : ST_WRITE;
               end
            end
            ST_READ: state <= ST_IDLE;
            ST_WRITE: state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Selected entry as seen by a read
   always_comb
   begin
      rdEntry = '0;
      unique case (ctrl.tsel)
         TSEL_STATIC:
            if (ctrl.index < 10'(STATIC_DEPTH))
               rdEntry = 72'(staticTab[ctrl.index[2:0]]);
         TSEL_VLAN:
            if (ctrl.index < 10'(VLAN_DEPTH))
               rdEntry = 72'(vlanTab[ctrl.index[3:0]]);
         TSEL_LEARN:
         begin
            rdEntry[55:0] = learnTab[ctrl.index];
            rdEntry[66] = (learnCount == 11'h000);
            // An empty table reports a zero count field rather than a wrapped one
            rdEntry[65:56] = (learnCount == 11'h000) ? 10'h000 :
               10'(learnCount - 11'h001);
            rdEntry[71] = learnWr;
         end
         TSEL_STATS:
            if (isMib)
               rdEntry[31:0] = mibTab[statIdx];
            else if (isDrop)
               rdEntry[15:0] = dropTab[dropIdx];
      endcase
   end

   // Data registers: software writes them, a read load overrides
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         word0 <= WORD_RESET;
         word1 <= WORD_RESET;
         word2 <= WORD_RESET;
         word3 <= WORD_RESET;
         topBits <= 3'h0;
         notReady <= 1'b0;
      end
      else if (loadNow)
      begin
         word0 <= rdEntry[15:0];
         word1 <= rdEntry[31:16];
         word2 <= rdEntry[47:32];
         word3 <= rdEntry[63:48];
         topBits <= rdEntry[66:64];
         notReady <= rdEntry[71];
      end
      else if (apbWr)
      begin
         if (isReg(paddr, IDX_DATA_W0))
            word0 <= pwdata[15:0];
         if (isReg(paddr, IDX_DATA_W1))
            word1 <= pwdata[15:0];
         if (isReg(paddr, IDX_DATA_W2))
            word2 <= pwdata[15:0];
         if (isReg(paddr, IDX_DATA_W3))
            word3 <= pwdata[15:0];
      end
   end

   // Writable tables; learned and statistics tables ignore writes
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < STATIC_DEPTH; i++)
            staticTab[i] <= STATIC_RESET;
         for (int i = 0; i < VLAN_DEPTH; i++)
            vlanTab[i] <= VLAN_RESET;
      end
      else if (commitNow)
      begin
         if (ctrl.tsel == TSEL_STATIC && ctrl.index < 10'(STATIC_DEPTH))
            staticTab[ctrl.index[2:0]] <= wrEntry[57:0];
         if (ctrl.tsel == TSEL_VLAN && ctrl.index < 10'(VLAN_DEPTH))
            vlanTab[ctrl.index[3:0]] <= wrEntry[19:0];
      end
   end

   // Learned table is filled by the switch only; too large to reset
   always_ff @(posedge clk_sys)
   begin
      if (learnWr)
         learnTab[learnIdx] <= learnEntry;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         learnCount <= 11'h000;
      else if (learnFlush)
         learnCount <= 11'h000;
      else if (learnNew && learnCount != LEARN_MAX)
         learnCount <= learnCount + 11'h001;
   end

   // Statistics: per-port counters clear on read, drop counters do not; a same-cycle count still lands
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < MIB_DEPTH; i++)
            mibTab[i] <= MIB_RESET;
         for (int i = 0; i < DROP_COUNT; i++)
            dropTab[i] <= 16'h0000;
      end
      else
      begin
         for (int i = 0; i < MIB_DEPTH; i++)
         begin
            ita_mib_t m;
            m = mibTab[i];
            if (loadNow && ctrl.tsel == TSEL_STATS && isMib && statIdx == 7'(i))
            begin
               m.count = 30'h0;
               m.overflow = 1'b0;
            end
            if (mibInc && mibIdx == 7'(i))
            begin
               if (m.count == MIB_COUNT_MAX)
                  m.overflow = 1'b1;
               m.count = m.count + 30'h1;
               m.valid = 1'b1;
            end
            mibTab[i] <= m;
         end
         for (int i = 0; i < DROP_COUNT; i++)
            if (dropInc[i])
               dropTab[i] <= dropTab[i] + 16'h0001;
      end
   end

   // Static lookup; lowest matching index wins
   always_comb
   begin
      next_hit = 1'b0;
      next_ovr = 1'b0;
      next_ports = 3'h0;
      for (int i = STATIC_DEPTH - 1; i >= 0; i--)
         if (staticTab[i].valid && staticTab[i].mac == lkpMac &&
             (!staticTab[i].useFid || staticTab[i].fid == lkpFid))
         begin
            next_hit = 1'b1;
            next_ovr = staticTab[i].override;
            next_ports = staticTab[i].ports;
         end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         lkpHit <= 1'b0;
         lkpPorts <= 3'h0;
      end
      else
      begin
         lkpHit <= lkpReq & next_hit;
         if (!lkpReq || !next_hit)
            lkpPorts <= 3'h0;
         else if (next_ovr)
            lkpPorts <= next_ports;
         else if ((rxDisable & portBit(lkpSrcPort)) != 3'h0)
            lkpPorts <= 3'h0;
         else
            lkpPorts <= next_ports & ~txDisable;
      end
   end

   a_busy_one_cycle: assert property (@(posedge clk_sys) disable iff (rst)
      ctrlWr && pwdata[12] |=> loadNow ##1 !loadNow)
      else $error("busy flag did not span exactly the load");
   a_read_loads_entry: assert property (@(posedge clk_sys) disable iff (rst)
      loadNow |=> word0 == $past(rdEntry[15:0]) && word2 == $past(rdEntry[47:32]))
      else $error("read did not load data registers");
   a_write_commits: assert property (@(posedge clk_sys) disable iff (rst)
      ctrlWr && !pwdata[12] && pwdata[11:10] == 2'h0 && pwdata[9:0] < 10'h008
      |-> ##COMMIT_CYCLES staticTab[$past(pwdata[2:0], 2)] == $past(wrEntry[57:0]))
      else $error("static write not committed");
   a_stats_cleared: assert property (@(posedge clk_sys) disable iff (rst)
      loadNow && ctrl.tsel == TSEL_STATS && isMib && !mibInc
      |=> mibTab[$past(statIdx)].count == 30'h0)
      else $error("counter not cleared after read");
   a_drop_kept: assert property (@(posedge clk_sys) disable iff (rst)
      loadNow && ctrl.tsel == TSEL_STATS && isDrop && dropInc == '0
      |=> dropTab[$past(dropIdx)] == $past(dropTab[dropIdx]))
      else $error("drop counter changed by read");
   a_no_match_none: assert property (@(posedge clk_sys) disable iff (rst)
      !next_hit |=> !lkpHit && lkpPorts == 3'h0)
      else $error("forwarded without valid match");
   a_override_mask: assert property (@(posedge clk_sys) disable iff (rst)
      lkpReq && next_hit && next_ovr |=> lkpPorts == $past(next_ports))
      else $error("override did not forward to mask");
   a_forward_subset: assert property (@(posedge clk_sys) disable iff (rst)
      lkpReq && next_hit |=> (lkpPorts & ~$past(next_ports)) == 3'h0)
      else $error("forwarded outside the mask");
   a_empty_flag: assert property (@(posedge clk_sys) disable iff (rst)
      loadNow && ctrl.tsel == TSEL_LEARN
      |=> topBits[2] == ($past(learnCount) == 11'h000))
      else $error("empty flag wrong");
   a_learn_ready: assert property (@(posedge clk_sys) disable iff (rst)
      loadNow && ctrl.tsel == TSEL_LEARN |=> notReady == $past(learnWr))
      else $error("not-ready flag wrong");

   c_static_read: cover property (@(posedge clk_sys) disable iff (rst)
      loadNow && ctrl.tsel == TSEL_STATIC);
   c_vlan_write: cover property (@(posedge clk_sys) disable iff (rst)
      commitNow && ctrl.tsel == TSEL_VLAN);
   c_mib_clear_inc: cover property (@(posedge clk_sys) disable iff (rst)
      loadNow && ctrl.tsel == TSEL_STATS && isMib && mibInc && mibIdx == statIdx);
   c_learn_not_ready: cover property (@(posedge clk_sys) disable iff (rst)
      loadNow && ctrl.tsel == TSEL_LEARN && learnWr);
endmodule
`default_nettype wire

//--- sim/tb_indirect_table_access.sv
/*
 Self-checking bench for the indirect table access block: APB register
 tasks, table reads and writes, counters, learned table and static lookup.
 Assumes ita_top with a zero-wait APB slave and a 100 MHz clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_indirect_table_access
   import ita_pkg::*;
;
   localparam logic [11:0] A_TOP = {IDX_DATA_TOP, 2'b00};
   localparam logic [11:0] A_W0 = {IDX_DATA_W0, 2'b00};
   localparam logic [11:0] A_W1 = {IDX_DATA_W1, 2'b00};
   localparam logic [11:0] A_W2 = {IDX_DATA_W2, 2'b00};
   localparam logic [11:0] A_W3 = {IDX_DATA_W3, 2'b00};
   localparam logic [11:0] A_CTRL = {IDX_CTRL, 2'b00};
   localparam logic [11:0] REG_ADDR [6] = '{A_TOP, A_W2, A_W3, A_W0, A_W1, A_CTRL};
   localparam logic [47:0] MAC7 = 48'h0123_4567_89ab;
   localparam logic [47:0] MAC0 = 48'h0a0b_0c0d_0e0f;
   localparam logic [47:0] MAC1 = 48'h1a1b_1c1d_1e1f;
   logic clk_sys, rst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdTmp;
   logic errTmp, learnWr, learnNew, learnFlush, mibInc, lkpReq, lkpHit;
   logic [9:0] learnIdx;
   ita_learn_t learnEntry;
   logic [6:0] mibIdx;
   logic [DROP_COUNT-1:0] dropInc;
   logic [47:0] lkpMac;
   logic [3:0] lkpFid;
   logic [1:0] lkpSrcPort;
   logic [2:0] txDisable, rxDisable, lkpPorts;
   logic [71:0] r;
   logic [63:0] e7;
   int failures, cmpCount;

   ita_top DUT (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .learnWr(learnWr), .learnNew(learnNew),
      .learnFlush(learnFlush), .learnIdx(learnIdx), .learnEntry(learnEntry),
      .mibInc(mibInc), .mibIdx(mibIdx), .dropInc(dropInc), .lkpReq(lkpReq),
      .lkpMac(lkpMac), .lkpFid(lkpFid), .lkpSrcPort(lkpSrcPort),
      .txDisable(txDisable), .rxDisable(rxDisable), .lkpHit(lkpHit),
      .lkpPorts(lkpPorts));

   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic chk(input string name, input logic [71:0] exp, input logic [71:0] got);
      cmpCount++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One idle cycle between transfers keeps psel from being driven twice per step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1)
         @(posedge clk_sys);
      rdTmp = prdata;
      errTmp = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic writeEntry(input ita_tsel_t t, input logic [9:0] idx, input logic [63:0] d);
      apb(1'b1, A_W0, {16'h0, d[15:0]});
      apb(1'b1, A_W1, {16'h0, d[31:16]});
      apb(1'b1, A_W2, {16'h0, d[47:32]});
      apb(1'b1, A_W3, {16'h0, d[63:48]});
      apb(1'b1, A_CTRL, {19'h0, 1'b0, t, idx});
   endtask

   // Result packs top[7:0] above the four words, so bit 71 is busy, 70 not ready
   task automatic readEntry(input ita_tsel_t t, input logic [9:0] idx);
      apb(1'b1, A_CTRL, {19'h0, 1'b1, t, idx});
      apb(1'b0, A_W0, 32'h0);
      r[15:0] = rdTmp[15:0];
      apb(1'b0, A_W1, 32'h0);
      r[31:16] = rdTmp[15:0];
      apb(1'b0, A_W2, 32'h0);
      r[47:32] = rdTmp[15:0];
      apb(1'b0, A_W3, 32'h0);
      r[63:48] = rdTmp[15:0];
      apb(1'b0, A_TOP, 32'h0);
      r[71:64] = rdTmp[7:0];
   endtask

   task automatic lookup(input logic [47:0] m, input logic [3:0] f, input logic h,
      input logic [2:0] p);
      @(posedge clk_sys);
      lkpReq <= 1'b1;
      lkpMac <= m;
      lkpFid <= f;
      @(posedge clk_sys);
      lkpReq <= 1'b0;
      @(posedge clk_sys);
      chk("lookup", {68'h0, h, p}, {68'h0, lkpHit, lkpPorts});
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmpCount, failures);
      if (failures == 0 && cmpCount > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      #200_000;
      failures++;
      $display("watchdog expired");
      final_report();
   end

   initial
   begin
      rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {learnWr, learnNew, learnFlush, learnIdx, learnEntry} = '0;
      {mibInc, mibIdx, dropInc, lkpReq, lkpMac, lkpFid} = '0;
      {lkpSrcPort, txDisable, rxDisable} = '0;
      failures = 0;
      cmpCount = 0;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b0, REG_ADDR[i], 32'h0);
         chk("reset value", 72'h0, {40'h0, rdTmp});
      end
      apb(1'b1, A_TOP, 32'hffff);
      apb(1'b0, A_TOP, 32'h0);
      chk("top read only", 72'h0, {40'h0, rdTmp});
      apb(1'b1, A_W2, 32'hffffffff);
      apb(1'b0, A_W2, 32'h0);
      chk("word upper bits", 72'hffff, {40'h0, rdTmp});
      apb(1'b1, 12'h004, 32'h1234);
      chk("unmapped error", 72'h1, {71'h0, errTmp});
      apb(1'b0, 12'h004, 32'h0);
      chk("unmapped data", 72'h0, {40'h0, rdTmp});
      $display("test registers done");
      // Static table: boundary index 7, neighbour must stay untouched
      e7 = {6'h0, 4'h5, 1'b1, 1'b0, 1'b1, 3'h5, MAC7};
      writeEntry(TSEL_STATIC, 10'd7, e7);
      readEntry(TSEL_STATIC, 10'd7);
      chk("static entry", {8'h0, e7}, r);
      readEntry(TSEL_STATIC, 10'd6);
      chk("static neighbour", 72'h0, r);
      lookup(MAC7, 4'h5, 1'b1, 3'h5);
      lookup(MAC7, 4'h4, 1'b0, 3'h0);
      writeEntry(TSEL_STATIC, 10'd0, {6'h0, 4'h0, 1'b0, 1'b1, 1'b1, 3'h7, MAC0});
      writeEntry(TSEL_STATIC, 10'd1, {6'h0, 4'h0, 1'b0, 1'b0, 1'b1, 3'h7, MAC1});
      txDisable <= 3'b010;
      lookup(MAC0, 4'h0, 1'b1, 3'h7);
      lookup(MAC1, 4'h0, 1'b1, 3'h5);
      txDisable <= 3'b000;
      rxDisable <= 3'b001;
      lookup(MAC0, 4'h0, 1'b1, 3'h7);
      lookup(MAC1, 4'h0, 1'b1, 3'h0);
      rxDisable <= 3'b000;
      writeEntry(TSEL_STATIC, 10'd1, {6'h0, 4'h0, 1'b0, 1'b0, 1'b1, 3'h0, MAC1});
      lookup(MAC1, 4'h0, 1'b1, 3'h0);
      writeEntry(TSEL_STATIC, 10'd7, e7 & ~(64'h1 << 51));
      lookup(MAC7, 4'h5, 1'b0, 3'h0);
      $display("test static done");
      readEntry(TSEL_VLAN, 10'd15);
      chk("vlan reset", 72'hf0001, r);
      writeEntry(TSEL_VLAN, 10'd3, {44'h0, 1'b0, 3'h2, 4'h9, 12'habc});
      readEntry(TSEL_VLAN, 10'd3);
      chk("vlan entry", {52'h0, 1'b0, 3'h2, 4'h9, 12'habc}, r);
      $display("test vlan done");
      // Last counter of each port block, incremented port-number times
      for (int p = 0; p < 3; p++)
      begin
         repeat (p + 1)
         begin
            @(posedge clk_sys);
            mibInc <= 1'b1;
            mibIdx <= 7'(32 * p + 31);
            @(posedge clk_sys);
            mibInc <= 1'b0;
         end
         readEntry(TSEL_STATS, 10'(32 * p + 31));
         chk("counter", {40'h0, 2'b01, 30'(p + 1)}, r);
         readEntry(TSEL_STATS, 10'(32 * p + 31));
         chk("counter cleared", 72'h0, {42'h0, r[29:0]});
      end
      @(posedge clk_sys);
      dropInc <= 6'h3f;
      @(posedge clk_sys);
      dropInc <= 6'h20;
      @(posedge clk_sys);
      dropInc <= 6'h00;
      for (int i = 0; i < 7; i++)
      begin
         readEntry(TSEL_STATS, 10'h100 + 10'(i > 5 ? 5 : i));
         chk("drop counter", (i >= 5) ? 72'h2 : 72'h1, r);
      end
      $display("test counters done");
      // Learned storage has no reset; fill index 0 so its load is defined
      @(posedge clk_sys);
      learnWr <= 1'b1;
      @(posedge clk_sys);
      learnWr <= 1'b0;
      readEntry(TSEL_LEARN, 10'd0);
      chk("learned empty", 72'h0400, {56'h0, r[71:56]});
      @(posedge clk_sys);
      learnWr <= 1'b1;
      learnIdx <= 10'h3ff;
      learnEntry <= {2'h3, 2'h2, 4'ha, 48'hfeed_cafe_0001};
      learnNew <= 1'b1;
      @(posedge clk_sys);
      learnWr <= 1'b0;
      repeat (2) @(posedge clk_sys);
      learnNew <= 1'b0;
      readEntry(TSEL_LEARN, 10'h3ff);
      chk("learned entry", {6'h0, 10'd2, 2'h3, 2'h2, 4'ha, 48'hfeed_cafe_0001}, r);
      // Load coincides with a learning write, so the result is flagged and retried
      apb(1'b1, A_CTRL, {19'h0, 1'b1, TSEL_LEARN, 10'h3ff});
      learnWr <= 1'b1;
      learnIdx <= 10'h3fe;
      @(posedge clk_sys);
      learnWr <= 1'b0;
      apb(1'b0, A_TOP, 32'h0);
      chk("learned not ready", 72'h1, {71'h0, rdTmp[TOP_NOT_READY_BIT]});
      readEntry(TSEL_LEARN, 10'h3ff);
      chk("learned retry", 72'h0, {71'h0, r[70]});
      writeEntry(TSEL_LEARN, 10'h3ff, 64'h0);
      readEntry(TSEL_LEARN, 10'h3ff);
      chk("learned read only", {6'h0, 10'd2, 2'h3, 2'h2, 4'ha, 48'hfeed_cafe_0001}, r);
      @(posedge clk_sys);
      learnFlush <= 1'b1;
      @(posedge clk_sys);
      learnFlush <= 1'b0;
      readEntry(TSEL_LEARN, 10'd0);
      chk("learned flushed", 72'h0400, {56'h0, r[71:56]});
      $display("test learned done");
      final_report();
   end
endmodule
`default_nettype wire
